//--- logic/sleep_wake_ctrl.sv
// Sleep entry, wake-up, status flags, I/O hold and serial program-mode entry
// Behaviour
// - Sleep instruction enters power-down mode
// - Sleep clears watchdog, power flag, sets timeout, oscillator off
// - I/O pins keep pre-sleep drive state
// - Watchdog reset never drives master clear pin
// - Wake on master clear, watchdog, or enabled interrupt
// - Watchdog or interrupt wake continues execution
// - Watchdog wake clears timeout flag
// - Power flag set at power-up, cleared by sleep
// - Prefetch next instruction, hold it for wake
// - Wake needs individual enable, ignores global enable
// - Global enable clear resumes after sleep instruction
// - Global enable set executes next, then vectors
// - Pending enabled interrupt at sleep wakes immediately
// - Every wake clears the watchdog counter
// - Unprotected program memory readable for verification
// - Four ID words reachable only in program mode
// - Only low four bits of ID stored
// - Program mode uses clock and data serial pins
// - Program mode entry zeroes the address counter
// - Command first, then data in or out
// - Watchdog resets when running, wakes when asleep
`timescale 1ns/1ps

module sleep_wake_ctrl #(
	parameter int IO_WIDTH = 13
) (
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [15:0]         wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                sleep_exec,
	input  wire logic [13:0]         next_instr,
	input  wire logic [2:0]          irq_flags,
	input  wire logic [2:0]          irq_enables,
	input  wire logic                global_irq_enable,
	input  wire logic                wdt_timeout,
	input  wire logic                master_clear_pin_n,
	input  wire logic                programming_high_level,
	input  wire logic                prog_clock_pin,
	input  wire logic                prog_data_in,
	output logic                     prog_data_out,
	output logic                     prog_data_oe,
	input  wire logic [IO_WIDTH-1:0] io_out_core,
	input  wire logic [IO_WIDTH-1:0] io_oe_core,
	output logic      [IO_WIDTH-1:0] io_out,
	output logic      [IO_WIDTH-1:0] io_oe,
	output logic                     core_clk_en,
	output logic                     core_reset,
	output logic                     osc_drive_en,
	output logic                     wdt_clear,
	output logic      [3:0]          wdt_prescale,
	output logic                     power_down_flag,
	output logic                     timeout_flag,
	output logic      [13:0]         held_instr,
	output logic                     resume,
	output logic                     vector_irq,
	output logic      [13:0]         vector_addr,
	output logic                     prog_mode,
	output logic      [13:0]         pm_addr,
	output logic      [13:0]         pm_wdata,
	output logic                     pm_we,
	input  wire logic [13:0]         pm_rdata
);

	// ==========================================================
	// State record
	typedef struct packed {
		sleep_pkg::state_t   state;
		logic                clr_s1;
		logic                clr_s2;
		logic                hv_s1;
		logic                hv_s2;
		logic                hv_d;
		logic                pclk_s1;
		logic                pclk_s2;
		logic                pclk_d;
		logic                pdat_s1;
		logic                pdat_s2;
		logic                wdt_s1;
		logic                wdt_s2;
		logic                wdt_d;
		logic                pwrdn_flag;
		logic                to_flag;
		logic                osc_on;
		logic                clk_en;
		logic                core_rst;
		logic                wdt_clr;
		logic                resume;
		logic                vec;
		logic [13:0]         vec_addr;
		logic                irq_wake;
		logic [13:0]         held;
		logic [IO_WIDTH-1:0] io_val;
		logic [IO_WIDTH-1:0] io_dir;
		logic [7:0]          option;
		logic [7:0]          config_fuses;
		logic [3:0][3:0]     id;
		logic [10:0]         ost_cnt;
		logic [13:0]         shift;
		logic [4:0]          bitcnt;
		logic [13:0]         pc;
		logic                pm_we;
		logic [13:0]         pm_wd;
		logic                dout;
		logic                doe;
		logic                ack;
		logic [7:0]          rdat;
		logic                prog;
	} regs_t;

	localparam logic [10:0] OST_LAST = 11'(sleep_pkg::OST_CYCLES - 1);
	localparam logic [4:0]  CMD_LAST = 5'(sleep_pkg::CMD_BITS - 1);
	localparam logic [4:0]  DAT_LAST = 5'(sleep_pkg::DATA_BITS - 1);

	regs_t r;
	regs_t n;

	// ==========================================================
	// Decoders
	// ID words sit in a four-word window of the program space
	function automatic logic is_id_addr(input logic [13:0] a);
		is_id_addr = (a[13:2] == sleep_pkg::ADDR_ID_BASE[13:2]);
	endfunction

	logic        wdt_en;
	logic        rc_mode;
	logic        irq_pend;
	logic        wdt_evt;
	logic        pclk_rise;
	logic        prog_entry;
	logic [13:0] bus_idx;
	logic [13:0] read_word;
	logic [5:0]  cmd;
	logic [13:0] load_word;
	logic [7:0]  status_word;
	sleep_pkg::state_t wake_state;

	// Decoded fuses, events and serial words
	always_comb begin
		wdt_en = r.config_fuses[sleep_pkg::CFG_WDT_EN];
		rc_mode = (r.config_fuses[sleep_pkg::CFG_OSC_HI:sleep_pkg::CFG_OSC_LO]
			== sleep_pkg::OSC_MODE_RC);
		irq_pend = |(irq_flags & irq_enables);
		wdt_evt = r.wdt_s2 & ~r.wdt_d & wdt_en;
		pclk_rise = r.pclk_s2 & ~r.pclk_d;
		prog_entry = r.hv_s2 & ~r.hv_d & ~r.pclk_s2 & ~r.pdat_s2 & r.clr_s2;
		wake_state = rc_mode ? sleep_pkg::ST_RESUME : sleep_pkg::ST_OST;
		bus_idx = wb_adr_i[15:2];
		cmd = {r.pdat_s2, r.shift[13:9]};
		load_word = {r.pdat_s2, r.shift[13:1]};
		read_word = 14'h0000;
		if (is_id_addr(r.pc)) begin
			read_word = {10'h000, r.id[r.pc[1:0]]};
		end else if (r.pc == sleep_pkg::ADDR_CONFIG) begin
			read_word = {6'h00, r.config_fuses};
		end else if (r.config_fuses[sleep_pkg::CFG_CP_HI:sleep_pkg::CFG_CP_LO]
			== sleep_pkg::CP_NONE) begin
			read_word = pm_rdata;
		end
		status_word = 8'h00;
		status_word[sleep_pkg::ST_OSC] = r.osc_on;
		status_word[sleep_pkg::ST_CLK] = r.clk_en;
		status_word[sleep_pkg::ST_IRQ_WAKE] = r.irq_wake;
		status_word[sleep_pkg::ST_PWRDN] = r.pwrdn_flag;
		status_word[sleep_pkg::ST_TO] = r.to_flag;
		status_word[7:5] = r.state;
	end

	// Next state; pins pass two flops before any logic reads them
	always_comb begin
		n = r;
		n.clr_s1 = master_clear_pin_n;
		n.clr_s2 = r.clr_s1;
		n.hv_s1 = programming_high_level;
		n.hv_s2 = r.hv_s1;
		n.hv_d = r.hv_s2;
		n.pclk_s1 = prog_clock_pin;
		n.pclk_s2 = r.pclk_s1;
		n.pclk_d = r.pclk_s2;
		n.pdat_s1 = prog_data_in;
		n.pdat_s2 = r.pdat_s1;
		n.wdt_s1 = wdt_timeout;
		n.wdt_s2 = r.wdt_s1;
		n.wdt_d = r.wdt_s2;
		n.core_rst = 1'b0;
		n.wdt_clr = 1'b0;
		n.resume = 1'b0;
		n.vec = 1'b0;
		n.pm_we = 1'b0;

		// Bus slave: answer one cycle after the request, unmapped reads zero
		n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
		if (wb_cyc_i && wb_stb_i && !r.ack) begin
			n.rdat = 8'h00;
			case (bus_idx)
				sleep_pkg::IDX_OPTION: begin
					n.rdat = r.option;
					if (wb_we_i && wb_sel_i[0]) begin
						n.option = wb_dat_i[7:0];
					end
				end
				sleep_pkg::IDX_CONFIG: n.rdat = r.config_fuses;
				sleep_pkg::IDX_STATUS: n.rdat = status_word;
				default: n.rdat = 8'h00;
			endcase
		end

		// Pins follow the core while it runs and freeze once its clock stops
		if (r.clk_en) begin
			n.io_val = io_out_core;
			n.io_dir = io_oe_core;
		end

		case (r.state)
			sleep_pkg::ST_RUN: begin
				n.clk_en = 1'b1;
				n.osc_on = 1'b1;
				if (wdt_evt) begin
					// Internal reset only; the master clear pin is an input
					n.core_rst = 1'b1;
					n.to_flag = 1'b0;
					n.pwrdn_flag = 1'b1;
					n.wdt_clr = 1'b1;
				end else if (sleep_exec) begin
					n.wdt_clr = 1'b1;
					n.pwrdn_flag = 1'b0;
					n.to_flag = 1'b1;
					n.held = next_instr;
					n.clk_en = 1'b0;
					n.osc_on = 1'b0;
					n.irq_wake = irq_pend;
					if (irq_pend) begin
						// Sleep completes but wakes at once
						n.state = wake_state;
						n.osc_on = 1'b1;
						n.ost_cnt = 11'h000;
					end else begin
						n.state = sleep_pkg::ST_SLEEP;
					end
				end
			end
			sleep_pkg::ST_SLEEP: begin
				n.clk_en = 1'b0;
				n.osc_on = 1'b0;
				if (irq_pend || wdt_evt) begin
					n.wdt_clr = 1'b1;
					n.irq_wake = irq_pend;
					n.osc_on = 1'b1;
					n.ost_cnt = 11'h000;
					n.state = wake_state;
					if (!irq_pend) begin
						n.to_flag = 1'b0;
					end
				end
			end
			sleep_pkg::ST_OST: begin
				// Crystal modes need the oscillator settled before the core runs
				n.ost_cnt = r.ost_cnt + 11'h001;
				if (r.ost_cnt == OST_LAST) begin
					n.state = sleep_pkg::ST_RESUME;
				end
			end
			sleep_pkg::ST_RESUME: begin
				n.clk_en = 1'b1;
				n.resume = 1'b1;
				n.vec = r.irq_wake & global_irq_enable;
				n.vec_addr = n.vec ? sleep_pkg::IRQ_VECTOR : 14'h0000;
				n.state = sleep_pkg::ST_RUN;
			end
			sleep_pkg::ST_PCMD: begin
				n.core_rst = 1'b1;
				if (pclk_rise) begin
					n.shift = {r.pdat_s2, r.shift[13:1]};
					n.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == CMD_LAST) begin
						n.bitcnt = 5'h00;
						case (cmd)
							sleep_pkg::CMD_LOAD: n.state = sleep_pkg::ST_PLOAD;
							sleep_pkg::CMD_READ: begin
								n.state = sleep_pkg::ST_PREAD;
								n.shift = read_word;
								n.dout = read_word[0];
								n.doe = 1'b1;
							end
							sleep_pkg::CMD_INC_ADDR: n.pc = r.pc + 14'h0001;
							sleep_pkg::CMD_LOAD_CFG: n.pc = sleep_pkg::ADDR_ID_BASE;
							default: n.pc = r.pc;
						endcase
					end
				end
			end
			sleep_pkg::ST_PLOAD: begin
				n.core_rst = 1'b1;
				if (pclk_rise) begin
					n.shift = load_word;
					n.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == DAT_LAST) begin
						n.bitcnt = 5'h00;
						n.state = sleep_pkg::ST_PCMD;
						if (is_id_addr(r.pc)) begin
							n.id[r.pc[1:0]] = load_word[sleep_pkg::ID_BITS-1:0];
						end else if (r.pc == sleep_pkg::ADDR_CONFIG) begin
							n.config_fuses = load_word[7:0];
						end else begin
							n.pm_wd = load_word;
							n.pm_we = 1'b1;
						end
					end
				end
			end
			sleep_pkg::ST_PREAD: begin
				n.core_rst = 1'b1;
				if (pclk_rise) begin
					// New bit after each rising clock; programmer samples just before the next rise
					n.shift = {1'b0, r.shift[13:1]};
					n.dout = r.shift[1];
					n.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == DAT_LAST) begin
						n.bitcnt = 5'h00;
						n.doe = 1'b0;
						n.dout = 1'b0;
						n.state = sleep_pkg::ST_PCMD;
					end
				end
			end
			default: n.state = sleep_pkg::ST_RUN;
		endcase

		// Leaving program mode when the high level drops is a full reset
		if (r.state >= sleep_pkg::ST_PCMD && !r.hv_s2) begin
			n.state = sleep_pkg::ST_RUN;
			n.core_rst = 1'b1;
			n.doe = 1'b0;
			n.dout = 1'b0;
		end

		// Program entry: address counter back to zero
		if (prog_entry) begin
			n.state = sleep_pkg::ST_PCMD;
			n.pc = sleep_pkg::ADDR_RESET;
			n.bitcnt = 5'h00;
			n.core_rst = 1'b1;
			n.clk_en = 1'b0;
			n.osc_on = 1'b1;
			n.doe = 1'b0;
		end

		// External master clear wins over everything: full reset, flags kept
		if (!r.clr_s2) begin
			n.state = sleep_pkg::ST_RUN;
			n.core_rst = 1'b1;
			n.clk_en = 1'b0;
			n.osc_on = 1'b1;
			n.doe = 1'b0;
			n.dout = 1'b0;
			n.wdt_clr = 1'b1;
		end

		// Mode flag kept in a flop so the port is not a state decode
		n.prog = (n.state >= sleep_pkg::ST_PCMD);
	end

	// Register the record; power-up sets both status flags
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			r <= '0;
			r.clr_s1 <= 1'b1;
			r.clr_s2 <= 1'b1;
			r.pwrdn_flag <= 1'b1;
			r.to_flag <= 1'b1;
			r.osc_on <= 1'b1;
			r.core_rst <= 1'b1;
			r.option <= sleep_pkg::OPTION_RESET;
			r.config_fuses <= sleep_pkg::CONFIG_RESET;
		end else begin
			r <= n;
		end
	end

	// ==========================================================
	// Outputs, each taken straight from a flop
	assign wb_dat_o        = {24'h000000, r.rdat};
	assign wb_ack_o        = r.ack;
	assign prog_data_out   = r.dout;
	assign prog_data_oe    = r.doe;
	assign io_out          = r.io_val;
	assign io_oe           = r.io_dir;
	assign core_clk_en     = r.clk_en;
	assign core_reset      = r.core_rst;
	assign osc_drive_en    = r.osc_on;
	assign wdt_clear       = r.wdt_clr;
	assign wdt_prescale    = r.option[sleep_pkg::OPT_PS_HI:0];
	assign power_down_flag = r.pwrdn_flag;
	assign timeout_flag    = r.to_flag;
	assign held_instr      = r.held;
	assign resume          = r.resume;
	assign vector_irq      = r.vec;
	assign vector_addr     = r.vec_addr;
	assign prog_mode       = r.prog;
	assign pm_addr         = r.pc;
	assign pm_wdata        = r.pm_wd;
	assign pm_we           = r.pm_we;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_pwrdn_only_sleep: assert property ($fell(power_down_flag) |-> $past(sleep_exec))
		else $error("power flag cleared without sleep");
	a_sleep_entry: assert property ((r.state == sleep_pkg::ST_RUN && sleep_exec && !wdt_evt
		&& !irq_pend && r.clr_s2 && !prog_entry) |=> (r.state == sleep_pkg::ST_SLEEP)
		&& !power_down_flag && timeout_flag && wdt_clear && !osc_drive_en)
		else $error("sleep entry effects missing");
	a_io_hold: assert property ((r.state == sleep_pkg::ST_SLEEP)[*2] |->
		$stable(io_out) && $stable(io_oe) && $stable(held_instr) && !core_clk_en)
		else $error("pins or instruction moved while asleep");
	a_prefetch_held: assert property ((r.state == sleep_pkg::ST_RUN && sleep_exec
		&& !wdt_evt && r.clr_s2) |=> held_instr == $past(next_instr))
		else $error("prefetched instruction not captured");
	a_wdt_wake: assert property ((r.state == sleep_pkg::ST_SLEEP && wdt_evt && !irq_pend
		&& r.clr_s2 && !prog_entry) |=> !timeout_flag && wdt_clear && !core_reset)
		else $error("watchdog wake wrong");
	a_irq_wake: assert property ((r.state == sleep_pkg::ST_SLEEP && irq_pend && r.clr_s2
		&& !prog_entry) |=> wdt_clear && r.irq_wake && r.state != sleep_pkg::ST_SLEEP)
		else $error("enabled interrupt did not wake");
	a_rc_no_delay: assert property ((r.state == sleep_pkg::ST_SLEEP && irq_pend && rc_mode
		&& r.clr_s2 && !prog_entry) |=> ##1 resume)
		else $error("resistor-capacitor wake was delayed");
	a_ost_hold: assert property ($rose(r.state == sleep_pkg::ST_OST) && r.clr_s2 |->
		(!core_clk_en && !resume)[*8])
		else $error("start-up delay cut short");
	a_irq_vector: assert property (vector_irq |-> resume && $past(global_irq_enable)
		&& vector_addr == sleep_pkg::IRQ_VECTOR)
		else $error("vector without global enable");
	a_early_wake: assert property ((r.state == sleep_pkg::ST_RUN && sleep_exec && irq_pend
		&& !wdt_evt && r.clr_s2 && !prog_entry) |=> r.state != sleep_pkg::ST_SLEEP
		&& !power_down_flag)
		else $error("pending interrupt did not wake at once");
	a_wdt_reset: assert property ((r.state == sleep_pkg::ST_RUN && wdt_evt && r.clr_s2
		&& !prog_entry) |=> core_reset && !timeout_flag && power_down_flag)
		else $error("watchdog reset wrong");
	a_prog_entry: assert property (prog_entry |=> prog_mode && pm_addr == 14'h0000)
		else $error("program entry address not zero");

endmodule

//--- logic/sleep_pkg.sv
// Constants and types shared by the sleep, wake and program-entry controller
package sleep_pkg;

	// ==========================================================
	// Register map: word index, byte address is four times the index
	localparam logic [13:0] IDX_STATUS   = 14'h0003;
	localparam logic [13:0] IDX_OPTION   = 14'h0081;
	localparam logic [13:0] IDX_CONFIG   = 14'h2007;
	localparam logic [7:0]  OPTION_RESET = 8'hFF;
	localparam logic [7:0]  CONFIG_RESET = 8'hFF;

	// ==========================================================
	// Field positions
	localparam int CFG_OSC_LO  = 0;
	localparam int CFG_OSC_HI  = 1;
	localparam int CFG_WDT_EN  = 2;
	localparam int CFG_CP_LO   = 4;
	localparam int CFG_CP_HI   = 5;
	localparam int OPT_PS_HI   = 3;
	localparam int ST_OSC      = 0;
	localparam int ST_CLK      = 1;
	localparam int ST_IRQ_WAKE = 2;
	localparam int ST_PWRDN    = 3;
	localparam int ST_TO       = 4;
	localparam logic [1:0] OSC_MODE_RC = 2'h3;
	localparam logic [1:0] CP_NONE     = 2'h3;

	// ==========================================================
	// Program space and serial programming
	localparam int          CMD_BITS     = 6;
	localparam int          DATA_BITS    = 14;
	localparam int          ID_BITS      = 4;
	localparam logic [13:0] ADDR_RESET   = 14'h0000;
	localparam logic [13:0] IRQ_VECTOR   = 14'h0004;
	localparam logic [13:0] ADDR_ID_BASE = 14'h2000;
	localparam logic [13:0] ADDR_CONFIG  = 14'h2007;
	localparam logic [5:0]  CMD_LOAD_CFG = 6'h00;
	localparam logic [5:0]  CMD_LOAD     = 6'h02;
	localparam logic [5:0]  CMD_READ     = 6'h04;
	localparam logic [5:0]  CMD_INC_ADDR = 6'h06;

	// ==========================================================
	// Timing: oscillator start-up delay
	localparam int OST_OSC_PERIODS = 1024;
	localparam int OSC_PERIOD_NS   = 10;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int OST_CYCLES      = (OST_OSC_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ==========================================================
	// Controller states
	typedef enum logic [2:0] {
		ST_RUN    = 3'h0,
		ST_SLEEP  = 3'h1,
		ST_OST    = 3'h2,
		ST_RESUME = 3'h3,
		ST_PCMD   = 3'h4,
		ST_PLOAD  = 3'h5,
		ST_PREAD  = 3'h6
	} state_t;

endpackage

//--- bench/prog_host.sv
// Behavioural programmer and reset source facing the sleep and wake controller
`timescale 1ns/1ps

module prog_host (
	input  wire logic sys_clk,
	input  wire logic prog_data_pin,
	output logic      prog_clock_pin,
	output logic      prog_data_drv,
	output logic      prog_data_en,
	output logic      master_clear_pin_n,
	output logic      programming_high_level
);
	// ==========================================================
	// Idle: link clock stands low, data released, no reset
	initial begin
		prog_clock_pin = 1'b0;
		prog_data_drv = 1'b0;
		prog_data_en = 1'b0;
		master_clear_pin_n = 1'b1;
		programming_high_level = 1'b0;
	end

	// Clock and data held low while the high level rises
	task automatic enter();
		prog_data_en <= 1'b1;
		prog_data_drv <= 1'b0;
		repeat (4) @(posedge sys_clk);
		programming_high_level <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask

	// Dropping the high level ends the mode with a full reset
	task automatic leave();
		programming_high_level <= 1'b0;
		prog_data_en <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask

	// Master clear level, driven by the external reset circuit
	task automatic set_clear(input logic lvl);
		master_clear_pin_n <= lvl;
	endtask

	// Half periods of four system cycles give the 80 ns link clock, LSB first
	task automatic send(input logic [13:0] v, input bit is_cmd);
		int n;
		n = is_cmd ? 6 : 14;
		prog_data_en <= 1'b1;
		for (int i = 0; i < n; i++) begin
			prog_data_drv <= v[i];
			repeat (4) @(posedge sys_clk);
			prog_clock_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			prog_clock_pin <= 1'b0;
		end
		// Hold time over: show the inverse so a stale bit is never read as valid
		prog_data_drv <= ~v[n-1];
		@(posedge sys_clk); // Next call's first bit lands in a later time step
	endtask

	// Sample just before each rise, when the device bit has long settled
	task automatic recv(output logic [13:0] v);
		v = 14'h0000;
		prog_data_en <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			repeat (4) @(posedge sys_clk);
			v[i] = prog_data_pin;
			prog_clock_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			prog_clock_pin <= 1'b0;
		end
	endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for the sleep, wake and program-entry controller
`timescale 1ns/1ps

module tb;
	logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [15:0] wb_adr_i;
	logic [3:0]  wb_sel_i, wdt_prescale;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic        sleep_exec, global_irq_enable, wdt_timeout, master_clear_pin_n;
	logic [13:0] next_instr, held_instr, vector_addr, pm_addr, pm_wdata, pm_rdata;
	logic [13:0] we_addr, we_data, rd, va;
	logic [2:0]  irq_flags, irq_enables;
	logic [12:0] io_out_core, io_oe_core, io_out, io_oe;
	logic        programming_high_level, prog_clock_pin, prog_data_in, prog_data_out;
	logic        prog_data_oe, prog_data_drv, prog_data_en, core_clk_en, core_reset;
	logic        osc_drive_en, wdt_clear, power_down_flag, timeout_flag, resume;
	logic        vector_irq, prog_mode, pm_we, got, vec, rst_seen;
	int          n_mismatch, checks_done, n_clear, n_we, c0;
	int          cycles = 0;

	// ==========================================================
	// Device, far side and shared data wire with a pull-up
	sleep_wake_ctrl u_sleep_wake_ctrl (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_exec, .next_instr,
		.irq_flags, .irq_enables, .global_irq_enable, .wdt_timeout, .master_clear_pin_n,
		.programming_high_level, .prog_clock_pin, .prog_data_in, .prog_data_out,
		.prog_data_oe, .io_out_core, .io_oe_core, .io_out, .io_oe, .core_clk_en,
		.core_reset, .osc_drive_en, .wdt_clear, .wdt_prescale, .power_down_flag,
		.timeout_flag, .held_instr, .resume, .vector_irq, .vector_addr, .prog_mode,
		.pm_addr, .pm_wdata, .pm_we, .pm_rdata);
	prog_host u_prog_host (.sys_clk, .prog_data_pin(prog_data_in), .prog_clock_pin,
		.prog_data_drv, .prog_data_en, .master_clear_pin_n, .programming_high_level);
	assign prog_data_in = prog_data_oe ? prog_data_out : (prog_data_en ? prog_data_drv : 1'b1);
	assign pm_rdata = pm_addr ^ 14'h1357;

	always #5 sys_clk = ~sys_clk;

	// Pulse counters and a hang limit well above the whole run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (wdt_clear === 1'b1) n_clear <= n_clear + 1;
		if (pm_we === 1'b1) begin
			n_we <= n_we + 1;
			we_addr <= pm_addr;
			we_data <= pm_wdata;
		end
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then one idle cycle
	task automatic wb(input logic we, input logic [15:0] adr, input logic [7:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h000000, d};
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic go_sleep(input logic [13:0] ni);
		sleep_exec <= 1'b1;
		next_instr <= ni;
		@(posedge sys_clk);
		sleep_exec <= 1'b0;
		next_instr <= ~ni; // The core moves on; the held word must not follow
	endtask

	// Waits for the resume pulse, noting any core reset on the way
	task automatic wake_wait(input int lim);
		got = 1'b0;
		rst_seen = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(posedge sys_clk);
			if (core_reset === 1'b1) rst_seen = 1'b1;
			if (resume === 1'b1) begin
				got = 1'b1;
				vec = vector_irq;
				va = vector_addr;
			end
		end
	endtask

	task automatic conclude();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_bus();
		wb(1'b0, 16'h0204, 8'h00);
		chk(q, 32'h000000FF);
		wb(1'b1, 16'h0204, 8'hA5);
		wb(1'b0, 16'h0204, 8'h00);
		chk(q, 32'h000000A5);
		chk(wdt_prescale, 4'h5);
		wb(1'b1, 16'h801C, 8'h00);
		wb(1'b0, 16'h801C, 8'h00);
		chk(q, 32'h000000FF);
		wb(1'b0, 16'h0100, 8'h00);
		chk(q, 32'h00000000);
		chk(power_down_flag, 1'b1);
	endtask

	// Flag pending but masked, then unmasked with the global enable set
	task automatic t_irq_vector();
		io_out_core <= 13'h0A5A;
		io_oe_core <= 13'h00FF;
		global_irq_enable <= 1'b1;
		irq_flags <= 3'h1;
		@(posedge sys_clk);
		c0 = n_clear;
		go_sleep(14'h1234);
		io_out_core <= 13'h1111;
		io_oe_core <= 13'h1F00;
		repeat (3) @(posedge sys_clk);
		chk(power_down_flag, 1'b0);
		chk(timeout_flag, 1'b1);
		chk(osc_drive_en, 1'b0);
		chk(n_clear - c0, 1);
		chk(core_clk_en, 1'b0);
		chk(held_instr, 14'h1234);
		chk(io_out, 13'h0A5A);
		chk(io_oe, 13'h00FF);
		wake_wait(20);
		chk(got, 1'b0);
		irq_enables <= 3'h1;
		wake_wait(10);
		chk(got, 1'b1);
		chk(vec, 1'b1);
		chk(va, 14'h0004);
		chk(n_clear - c0, 2);
		irq_flags <= 3'h0;
	endtask

	task automatic t_wakes();
		// Comparator wake with the global enable clear runs on in line
		global_irq_enable <= 1'b0;
		irq_enables <= 3'h4;
		go_sleep(14'h0ABC);
		repeat (3) @(posedge sys_clk);
		irq_flags <= 3'h4;
		wake_wait(10);
		chk(got, 1'b1);
		chk(vec, 1'b0);
		chk(rst_seen, 1'b0);
		// Source already pending when the sleep instruction runs
		irq_flags <= 3'h2;
		irq_enables <= 3'h2;
		@(posedge sys_clk);
		go_sleep(14'h0001);
		wake_wait(10);
		chk(got, 1'b1);
		irq_flags <= 3'h0;
		irq_enables <= 3'h0;
		// Watchdog wake continues and reports its cause
		repeat (2) @(posedge sys_clk);
		go_sleep(14'h0002);
		repeat (3) @(posedge sys_clk);
		c0 = n_clear;
		wdt_timeout <= 1'b1;
		wake_wait(12);
		chk(got, 1'b1);
		chk(rst_seen, 1'b0);
		chk(timeout_flag, 1'b0);
		chk(n_clear - c0, 1);
		wdt_timeout <= 1'b0;
		repeat (4) @(posedge sys_clk);
		// External clear while asleep is a full reset
		go_sleep(14'h0003);
		repeat (3) @(posedge sys_clk);
		u_prog_host.set_clear(1'b0);
		repeat (5) @(posedge sys_clk);
		chk(core_reset, 1'b1);
		chk(power_down_flag, 1'b0);
		u_prog_host.set_clear(1'b1);
		repeat (6) @(posedge sys_clk);
		chk(core_clk_en, 1'b1);
		// Watchdog time-out while running resets the core
		wdt_timeout <= 1'b1;
		wake_wait(10);
		chk(rst_seen, 1'b1);
		chk(timeout_flag, 1'b0);
		wdt_timeout <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic t_program();
		u_prog_host.enter();
		chk(prog_mode, 1'b1);
		chk(pm_addr, 14'h0000);
		c0 = n_we;
		u_prog_host.send({8'h00, sleep_pkg::CMD_LOAD}, 1'b1);
		u_prog_host.send(14'h2ABC, 1'b0);
		repeat (8) @(posedge sys_clk);
		chk(n_we - c0, 1);
		chk(we_data, 14'h2ABC);
		chk(we_addr, 14'h0000);
		u_prog_host.send({8'h00, sleep_pkg::CMD_READ}, 1'b1);
		u_prog_host.recv(rd);
		chk(rd, 14'h1357);
		u_prog_host.send({8'h00, sleep_pkg::CMD_LOAD_CFG}, 1'b1);
		u_prog_host.send({8'h00, sleep_pkg::CMD_LOAD}, 1'b1);
		u_prog_host.send(14'h3FF5, 1'b0);
		u_prog_host.send({8'h00, sleep_pkg::CMD_READ}, 1'b1);
		u_prog_host.recv(rd);
		chk(rd, 14'h0005);
		// Step to the fuse word and pick a crystal mode for the start-up test
		repeat (7) u_prog_host.send({8'h00, sleep_pkg::CMD_INC_ADDR}, 1'b1);
		u_prog_host.send({8'h00, sleep_pkg::CMD_LOAD}, 1'b1);
		u_prog_host.send(14'h00F5, 1'b0);
		u_prog_host.send({8'h00, sleep_pkg::CMD_READ}, 1'b1);
		u_prog_host.recv(rd);
		chk(rd, 14'h00F5);
		chk(prog_data_oe, 1'b0);
		u_prog_host.leave();
		chk(prog_mode, 1'b0);
		wb(1'b0, 16'h8000, 8'h00);
		chk(q, 32'h00000000);
		wb(1'b0, 16'h801C, 8'h00);
		chk(q, 32'h000000F5);
	endtask

	// Crystal mode: resume comes one start-up delay later than in RC mode
	task automatic t_ost();
		irq_enables <= 3'h1;
		go_sleep(14'h0155);
		repeat (3) @(posedge sys_clk);
		irq_flags <= 3'h1;
		wake_wait(sleep_pkg::OST_CYCLES + 2);
		chk(got, 1'b0);
		chk(core_clk_en, 1'b0);
		wake_wait(1);
		chk(got, 1'b1);
		chk(core_clk_en, 1'b1);
		chk(rst_seen, 1'b0);
		irq_flags <= 3'h0;
		irq_enables <= 3'h0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, sleep_exec} = 6'h01 << 4;
		{global_irq_enable, wdt_timeout, irq_flags, irq_enables} = 8'h00;
		{wb_adr_i, wb_sel_i, wb_dat_i, next_instr} = 66'h0;
		{io_out_core, io_oe_core} = 26'h0;
		{n_mismatch, checks_done, n_clear, n_we} = 128'h0;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_bus();
		t_irq_vector();
		t_wakes();
		t_program();
		t_ost();
		conclude();
	end
endmodule
